// ---- hdl/byte_ram.sv ----
`timescale 1ns/1ps
// byte-wide storage with per-bit write mask; volatile, no reset of contents
module byte_ram #(
    parameter int DEPTH = 128,
    parameter int AW    = 7
) (
    input  wire logic          ref_clk,
    input  wire logic          clk_en,
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    wdata,
    input  wire logic [7:0]    wmask,
    output logic      [7:0]    rdata
);
    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;
    } ram_s;
    ram_s st_q;
    ram_s st_d;

    // masked write keeps untouched bits, so bit set/clear needs no read-modify-write
    always_comb begin
        st_d = st_q;
        if (we && (32'(addr) < DEPTH)) begin
            st_d.mem[addr] = (st_q.mem[addr] & ~wmask) | (wdata & wmask);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (clk_en) begin
            st_q <= st_d;
        end
    end

    assign rdata = (32'(addr) < DEPTH) ? st_q.mem[addr] : 8'h00;
endmodule : byte_ram

// ---- hdl/dmem_bank.sv ----
`timescale 1ns/1ps
module dmem_bank
    import dmem_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic       clk_en,
    input  wire logic       sys_rst,
    input  wire logic       wdt_reset,
    input  wire logic       low_power,
    input  wire logic       acc_valid,
    input  wire logic       acc_write,
    input  wire logic [7:0] acc_addr,
    input  wire logic [7:0] acc_wdata,
    input  wire logic [7:0] acc_wmask,
    output logic      [7:0] acc_rdata,
    output logic            rd_valid,
    output logic            sfr_sel,
    output logic      [7:0] sfr_addr,
    output logic            sfr_we,
    output logic      [7:0] sfr_wdata,
    output logic      [7:0] sfr_wmask,
    input  wire logic [7:0] sfr_rdata,
    input  wire logic       sfr_used,
    input  wire logic       sfr_ro,
    output logic      [7:0] pointer_a,
    output logic      [7:0] pointer_b,
    output logic      [2:0] bank_select_field
);
    typedef enum logic [1:0] {
        TGT_NONE = 2'b00,
        TGT_CORE = 2'b01,
        TGT_GPR  = 2'b10,
        TGT_LCD  = 2'b11
    } tgt_e;

    typedef struct packed {
        logic [7:0] ptr_a;
        logic [7:0] ptr_b;
        logic [2:0] bank;
        logic [7:0] rdata;
        logic       rvalid;
        logic       sel;
        logic [7:0] saddr;
        logic       swe;
        logic [7:0] swdata;
        logic [7:0] swmask;
    } bank_s;

    bank_s st_q;
    bank_s st_d;

    logic       clear_bank;
    logic [7:0] gpr_rdata;
    logic [7:0] lcd_rdata;
    logic [2:0] eff_bank;
    logic [7:0] eff_addr;
    logic       via_port;
    logic       self_hit;
    tgt_e       tgt;
    logic       sfr_hit;
    logic       gpr_we;
    logic       lcd_we;
    logic [7:0] merged;

    reset_hold u_reset_hold (
        .ref_clk    (ref_clk),
        .rst_b      (rst_b),
        .clk_en     (clk_en),
        .sys_rst    (sys_rst),
        .wdt_reset  (wdt_reset),
        .low_power  (low_power),
        .clear_bank (clear_bank)
    );

    // resolve the real bank and address of an access before decoding it
    always_comb begin
        via_port = 1'b0;
        eff_bank = BANK_0;
        eff_addr = acc_addr;
        if (acc_addr == OFS_PORT_A) begin
            via_port = 1'b1;
            eff_bank = BANK_0;
            eff_addr = st_q.ptr_a;
        end else if (acc_addr == OFS_PORT_B) begin
            via_port = 1'b1;
            eff_bank = st_q.bank;
            eff_addr = st_q.ptr_b;
        end
        // ports never chain, so a pointer aimed at a port is a dead location
        self_hit = via_port && (eff_bank == BANK_0)
                   && ((eff_addr == OFS_PORT_A) || (eff_addr == OFS_PORT_B));
    end

    // region decode per bank
    always_comb begin
        tgt     = TGT_NONE;
        sfr_hit = 1'b0;
        if (self_hit) begin
            tgt = TGT_NONE;
        end else if (eff_bank == BANK_0) begin
            if (eff_addr >= GPR_FIRST) begin
                tgt = TGT_GPR;
            end else if ((eff_addr == OFS_PTR_A) || (eff_addr == OFS_PTR_B)
                         || (eff_addr == OFS_BANK_SEL)) begin
                tgt = TGT_CORE;
            end else if (eff_addr <= SFR_LAST) begin
                sfr_hit = 1'b1;
            end
        end else if (eff_bank == BANK_4) begin
            if (eff_addr <= LCD_LAST) begin
                tgt = TGT_LCD;
            end
        end else begin
            tgt = TGT_NONE;
        end
    end

    assign gpr_we = clk_en && acc_valid && acc_write && (tgt == TGT_GPR);
    assign lcd_we = clk_en && acc_valid && acc_write && (tgt == TGT_LCD);

    byte_ram #(
        .DEPTH (GPR_DEPTH),
        .AW    (7)
    ) u_gpr (
        .ref_clk (ref_clk),
        .clk_en  (clk_en),
        .we      (gpr_we),
        .addr    (eff_addr[6:0]),
        .wdata   (acc_wdata),
        .wmask   (acc_wmask),
        .rdata   (gpr_rdata)
    );

    byte_ram #(
        .DEPTH (LCD_DEPTH),
        .AW    (5)
    ) u_lcd (
        .ref_clk (ref_clk),
        .clk_en  (clk_en),
        .we      (lcd_we),
        .addr    (eff_addr[4:0]),
        .wdata   (acc_wdata),
        .wmask   (acc_wmask),
        .rdata   (lcd_rdata)
    );

    // masked write on the core registers, same bit-op semantics as ram
    function automatic logic [7:0] apply_mask(input logic [7:0] old_v,
                                              input logic [7:0] new_v,
                                              input logic [7:0] msk);
        apply_mask = (old_v & ~msk) | (new_v & msk);
    endfunction : apply_mask

    assign merged = apply_mask({5'h00, st_q.bank}, acc_wdata, acc_wmask);

    // next state: core registers, read data and the peripheral strobe
    always_comb begin
        st_d        = st_q;
        st_d.rvalid = acc_valid && !acc_write;
        st_d.sel    = acc_valid && sfr_hit;
        st_d.saddr  = eff_addr;
        st_d.swe    = acc_valid && acc_write && sfr_hit && !sfr_ro;
        st_d.swdata = acc_wdata;
        st_d.swmask = acc_wmask;
        if (acc_valid && !acc_write) begin
            case (tgt)
                TGT_GPR:  st_d.rdata = gpr_rdata;
                TGT_LCD:  st_d.rdata = lcd_rdata;
                TGT_CORE: begin
                    if (eff_addr == OFS_PTR_A) begin
                        st_d.rdata = st_q.ptr_a;
                    end else if (eff_addr == OFS_PTR_B) begin
                        st_d.rdata = st_q.ptr_b;
                    end else begin
                        st_d.rdata = {5'h00, st_q.bank};
                    end
                end
                default: begin
                    // peripheral space answers combinationally; holes read zero
                    if (sfr_hit && sfr_used) begin
                        st_d.rdata = sfr_rdata;
                    end else begin
                        st_d.rdata = READ_ZERO;
                    end
                end
            endcase
        end
        if (acc_valid && acc_write && (tgt == TGT_CORE)) begin
            if (eff_addr == OFS_PTR_A) begin
                st_d.ptr_a = apply_mask(st_q.ptr_a, acc_wdata, acc_wmask);
            end else if (eff_addr == OFS_PTR_B) begin
                st_d.ptr_b = apply_mask(st_q.ptr_b, acc_wdata, acc_wmask);
            end else begin
                st_d.bank = merged[BANK_LSB +: BANK_W];
            end
        end
        // a qualifying reset request wins over a same-cycle bank write
        if (clear_bank) begin
            st_d.bank = BANK_RST;
        end
    end

    // rst_b clears every field; a sys_rst request only ever reaches the bank field, never the pointers
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q       <= '0;
            st_q.ptr_a <= PTR_RST;
            st_q.ptr_b <= PTR_RST;
            st_q.bank  <= BANK_RST;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    assign acc_rdata         = st_q.rdata;
    assign rd_valid          = st_q.rvalid;
    assign sfr_sel           = st_q.sel;
    assign sfr_addr          = st_q.saddr;
    assign sfr_we            = st_q.swe;
    assign sfr_wdata         = st_q.swdata;
    assign sfr_wmask         = st_q.swmask;
    assign pointer_a         = st_q.ptr_a;
    assign pointer_b         = st_q.ptr_b;
    assign bank_select_field = st_q.bank;

    AST_BANK_LEGAL_READ: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && acc_valid && !acc_write && (acc_addr == OFS_BANK_SEL)
        |=> acc_rdata[7:3] == 5'h00)
        else $error("bank select upper bits not zero");

    AST_SELF_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && acc_valid && !acc_write && self_hit |=> acc_rdata == 8'h00)
        else $error("self-pointing indirect read not zero");

    AST_RO_PROTECT: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && acc_valid && acc_write && sfr_ro |=> !sfr_we)
        else $error("write strobe to protected register");

    AST_UNUSED_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && acc_valid && !acc_write && sfr_hit && !sfr_used |=> acc_rdata == 8'h00)
        else $error("unused location read not zero");

    AST_PTR_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && acc_valid && acc_write && (acc_addr == OFS_PTR_A) && (acc_wmask == 8'hff)
        |=> pointer_a == $past(acc_wdata))
        else $error("pointer a write lost");

    AST_RESET_BANK: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && sys_rst && !(wdt_reset && low_power) ##1 clk_en
        |=> bank_select_field == BANK_0)
        else $error("bank not cleared by reset");

    AST_WDT_KEEP: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && sys_rst && wdt_reset && low_power && !clear_bank
        && !(acc_valid && acc_write && (tgt == TGT_CORE) && (eff_addr == OFS_BANK_SEL))
        |=> $stable(bank_select_field))
        else $error("bank changed by low-power watchdog reset");

    AST_DIRECT_BANK0: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && acc_valid && (acc_addr >= GPR_FIRST) |-> tgt == TGT_GPR)
        else $error("direct access left bank 0");

    AST_PORT_A_BANK0: assert property (@(posedge ref_clk) disable iff (!rst_b)
        acc_valid && (acc_addr == OFS_PORT_A) |-> tgt != TGT_LCD)
        else $error("port a reached another bank");

    AST_RESERVED_BANK: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && acc_valid && !acc_write && (acc_addr == OFS_PORT_B)
        && (st_q.bank != BANK_0) && (st_q.bank != BANK_4) |=> acc_rdata == 8'h00)
        else $error("reserved bank read not zero");

    // write strobes only ever land in the region and bank that the decode allows
    AST_GPR_WRITE_BANK0: assert property (@(posedge ref_clk) disable iff (!rst_b)
        gpr_we |-> (eff_bank == BANK_0) && (eff_addr >= GPR_FIRST))
        else $error("general RAM written outside bank 0 upper half");

    AST_LCD_WRITE_RANGE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        lcd_we |-> (eff_bank == BANK_4) && (eff_addr <= LCD_LAST))
        else $error("display memory written out of range");

    AST_LCD_PAST_END: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && acc_valid && !acc_write && (acc_addr == OFS_PORT_B)
        && (st_q.bank == BANK_4) && (st_q.ptr_b > LCD_LAST) |=> acc_rdata == 8'h00)
        else $error("display read past its end not zero");

    AST_PORT_A_NO_LCD: assert property (@(posedge ref_clk) disable iff (!rst_b)
        acc_valid && acc_write && (acc_addr == OFS_PORT_A) |-> !lcd_we)
        else $error("first port wrote the display memory");

    AST_ONLY_PORT_B_BANKS: assert property (@(posedge ref_clk) disable iff (!rst_b)
        acc_valid && (acc_addr != OFS_PORT_B) |-> !lcd_we)
        else $error("display memory reached without the second port");

    AST_RESERVED_NO_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        acc_valid && acc_write && (acc_addr == OFS_PORT_B)
        && (st_q.bank != BANK_0) && (st_q.bank != BANK_4) |-> !gpr_we && !lcd_we)
        else $error("reserved bank write landed");

    // a port address is a window onto its pointer, never storage of its own
    AST_SELF_NO_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && acc_valid && acc_write && self_hit
        |=> !sfr_we && $stable(pointer_a) && $stable(pointer_b))
        else $error("self-pointing indirect write had an effect");

    AST_PORT_NO_STROBE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && acc_valid && ((acc_addr == OFS_PORT_A) || (acc_addr == OFS_PORT_B))
        |=> !(sfr_sel && ((sfr_addr == OFS_PORT_A) || (sfr_addr == OFS_PORT_B))))
        else $error("port address strobed as a peripheral register");

    AST_SFR_STROBE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && acc_valid && sfr_hit |=> sfr_sel && (sfr_addr == $past(eff_addr)))
        else $error("peripheral access not strobed at its address");

    // core registers are internal and never leak onto the peripheral strobe
    AST_CORE_NO_STROBE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && acc_valid && (tgt == TGT_CORE) |=> !sfr_sel)
        else $error("core register access strobed the peripheral side");

    AST_PTR_B_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && acc_valid && acc_write && (acc_addr == OFS_PTR_B) && (acc_wmask == 8'hff)
        |=> pointer_b == $past(acc_wdata))
        else $error("pointer b write lost");

    AST_BANK_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en && acc_valid && acc_write && (acc_addr == OFS_BANK_SEL)
        && (acc_wmask == 8'hff) && !clear_bank
        |=> {5'h00, bank_select_field} == ($past(acc_wdata) & 8'h07))
        else $error("bank select write lost");
endmodule : dmem_bank

// ---- hdl/dmem_pkg.sv ----
package dmem_pkg;
    // bank 0 map of the five core registers
    localparam logic [7:0] OFS_PORT_A   = 8'h00;
    localparam logic [7:0] OFS_PTR_A    = 8'h01;
    localparam logic [7:0] OFS_PORT_B   = 8'h02;
    localparam logic [7:0] OFS_PTR_B    = 8'h03;
    localparam logic [7:0] OFS_BANK_SEL = 8'h04;
    // region bounds
    localparam logic [7:0] SFR_LAST     = 8'h7f;
    localparam logic [7:0] GPR_FIRST    = 8'h80;
    localparam logic [7:0] LCD_LAST     = 8'h13;
    localparam int         LCD_DEPTH    = 20;
    localparam int         GPR_DEPTH    = 128;
    // bank select field
    localparam int         BANK_LSB     = 0;
    localparam int         BANK_W       = 3;
    localparam logic [2:0] BANK_0       = 3'h0;
    localparam logic [2:0] BANK_4       = 3'h4;
    localparam logic [2:0] BANK_RST     = 3'h0;
    localparam logic [7:0] PTR_RST      = 8'h00;
    localparam logic [7:0] READ_ZERO    = 8'h00;
endpackage : dmem_pkg

// ---- hdl/reset_hold.sv ----
`timescale 1ns/1ps
// decides whether a reset request clears the bank selection
module reset_hold (
    input  wire logic ref_clk,
    input  wire logic rst_b,
    input  wire logic clk_en,
    input  wire logic sys_rst,
    input  wire logic wdt_reset,
    input  wire logic low_power,
    output logic      clear_bank
);
    typedef struct packed {
        logic clr;
    } hold_s;
    hold_s st_q;
    hold_s st_d;

    // a watchdog reset taken while idle or asleep keeps the bank
    always_comb begin
        st_d     = st_q;
        st_d.clr = sys_rst && !(wdt_reset && low_power);
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    assign clear_bank = st_q.clr;
endmodule : reset_hold

// ---- verification/data_memory_bank_indirect_access_test.sv ----
`timescale 1ns/1ps
module data_memory_bank_indirect_access_test
    import dmem_pkg::*;
;
    logic       ref_clk, rst_b, clk_en, sys_rst, wdt_reset, low_power;
    logic       acc_valid, acc_write, rd_valid, sfr_sel, sfr_we, sfr_used, sfr_ro;
    logic [7:0] acc_addr, acc_wdata, acc_wmask, acc_rdata, sfr_addr, sfr_wdata, sfr_wmask;
    logic [7:0] sfr_rdata, pointer_a, pointer_b;
    logic [2:0] bank_select_field;
    int         failures, checks_done;

    dmem_bank dut (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .sys_rst(sys_rst),
        .wdt_reset(wdt_reset), .low_power(low_power), .acc_valid(acc_valid),
        .acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
        .acc_wmask(acc_wmask), .acc_rdata(acc_rdata), .rd_valid(rd_valid),
        .sfr_sel(sfr_sel), .sfr_addr(sfr_addr), .sfr_we(sfr_we), .sfr_wdata(sfr_wdata),
        .sfr_wmask(sfr_wmask), .sfr_rdata(sfr_rdata), .sfr_used(sfr_used), .sfr_ro(sfr_ro),
        .pointer_a(pointer_a), .pointer_b(pointer_b), .bank_select_field(bank_select_field));

    sfr_model periph (.ref_clk(ref_clk), .rst_b(rst_b), .acc_addr(acc_addr),
        .pointer_a(pointer_a), .pointer_b(pointer_b), .bank_select_field(bank_select_field),
        .sfr_sel(sfr_sel), .sfr_addr(sfr_addr), .sfr_we(sfr_we), .sfr_wdata(sfr_wdata),
        .sfr_wmask(sfr_wmask), .sfr_rdata(sfr_rdata), .sfr_used(sfr_used), .sfr_ro(sfr_ro));

    // 40 MHz
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("failures %0d, checks %0d", failures, checks_done);
        if (failures == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test

    // one-cycle request launched at a falling edge, taken at the next rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
        @(negedge ref_clk);
        {acc_valid, acc_write, acc_addr, acc_wdata, acc_wmask} = {2'b11, a, d, m};
        @(negedge ref_clk);
        acc_valid = 1'b0;
    endtask : wr

    // rd_valid stands for one cycle only, so it is looked at in that cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge ref_clk);
        {acc_valid, acc_write, acc_addr, acc_wdata, acc_wmask} = {2'b10, a, 16'h0000};
        @(negedge ref_clk);
        acc_valid = 1'b0;
        check({7'h00, rd_valid}, 8'h01);
        check(acc_rdata, exp);
    endtask : rd

    // qualifiers raised with a one-cycle reset request and held for three cycles after it
    task automatic core_reset(input logic wdt, input logic lp);
        @(negedge ref_clk);
        {sys_rst, wdt_reset, low_power} = {1'b1, wdt, lp};
        @(negedge ref_clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge ref_clk);
        {wdt_reset, low_power} = 2'b00;
    endtask : core_reset

    // a hang is cut well beyond the roughly 140 cycles the sequence needs
    initial begin
        #(3000 * 25);
        failures++;
        finish_test();
    end

    initial begin
        {rst_b, sys_rst, wdt_reset, low_power, acc_valid, acc_write} = 6'h00;
        {acc_addr, acc_wdata, acc_wmask} = 24'h000000;
        clk_en = 1'b1;
        repeat (5) @(negedge ref_clk);
        rst_b = 1'b1;
        check({5'h00, bank_select_field}, 8'h00);
        rd(OFS_BANK_SEL, 8'h00);
        // general RAM, both ends, then single-bit set and clear
        wr(8'h80, 8'ha5, 8'hff);
        check({7'h00, rd_valid}, 8'h00);
        wr(8'hff, 8'h5a, 8'hff);
        rd(8'h80, 8'ha5);
        rd(8'hff, 8'h5a);
        wr(8'h80, 8'hff, 8'h08);
        wr(8'h80, 8'h00, 8'h01);
        rd(8'h80, 8'hac);
        // first pointer and its port
        wr(OFS_PTR_A, 8'h90, 8'hff);
        rd(OFS_PTR_A, 8'h90);
        wr(OFS_PORT_A, 8'h55, 8'hff);
        rd(8'h90, 8'h55);
        rd(OFS_PORT_A, 8'h55);
        wr(OFS_PTR_A, OFS_PORT_A, 8'hff);
        wr(OFS_PORT_A, 8'h77, 8'hff);
        rd(OFS_PORT_A, 8'h00);
        wr(OFS_PTR_A, OFS_PORT_B, 8'hff);
        rd(OFS_PORT_A, 8'h00);
        // special function space: plain, read-only, unused; strobes stand one cycle
        wr(8'h05, 8'hc3, 8'hff);
        check({7'h00, sfr_sel}, 8'h01);
        check({7'h00, sfr_we}, 8'h01);
        check(sfr_addr, 8'h05);
        check(sfr_wdata, 8'hc3);
        rd(8'h05, 8'hc3);
        wr(8'h08, 8'h00, 8'hff);
        check({7'h00, sfr_sel}, 8'h01);
        check({7'h00, sfr_we}, 8'h00);
        rd(8'h08, 8'h3c);
        rd(8'h06, 8'h00);
        rd(8'h7f, 8'h00);
        wr(OFS_PTR_A, 8'h05, 8'hff);
        rd(OFS_PORT_A, 8'hc3);
        // single-bit write through the first port reaches the pointed register
        wr(OFS_PORT_A, 8'hff, 8'h08);
        check(sfr_addr, 8'h05);
        check(sfr_wmask, 8'h08);
        rd(8'h05, 8'hcb);
        // display memory through the second port, last place and one past it
        wr(OFS_BANK_SEL, {5'h00, BANK_4}, 8'hff);
        rd(OFS_BANK_SEL, 8'h04);
        wr(OFS_PTR_B, LCD_LAST, 8'hff);
        rd(OFS_PTR_B, LCD_LAST);
        check(pointer_b, LCD_LAST);
        wr(OFS_PORT_B, 8'h3c, 8'hff);
        rd(OFS_PORT_B, 8'h3c);
        rd(LCD_LAST, 8'h00);
        wr(OFS_PTR_B, 8'h14, 8'hff);
        wr(OFS_PORT_B, 8'h11, 8'hff);
        rd(OFS_PORT_B, 8'h00);
        wr(OFS_PTR_B, 8'h80, 8'hff);
        rd(OFS_PORT_B, 8'h00);
        wr(OFS_PTR_A, 8'h80, 8'hff);
        rd(OFS_PORT_A, 8'hac);
        rd(8'h80, 8'hac);
        // reserved bank code, upper bits dropped
        wr(OFS_BANK_SEL, 8'hff, 8'hff);
        rd(OFS_BANK_SEL, 8'h07);
        wr(OFS_PORT_B, 8'h99, 8'hff);
        rd(OFS_PORT_B, 8'h00);
        rd(8'h80, 8'hac);
        wr(OFS_BANK_SEL, {5'h00, BANK_0}, 8'hff);
        rd(OFS_PORT_B, 8'hac);
        // watchdog reset in low power keeps the bank, any other reset clears it
        wr(OFS_BANK_SEL, {5'h00, BANK_4}, 8'hff);
        core_reset(1'b1, 1'b1);
        check({5'h00, bank_select_field}, 8'h04);
        core_reset(1'b1, 1'b0);
        check({5'h00, bank_select_field}, 8'h00);
        wr(OFS_BANK_SEL, {5'h00, BANK_4}, 8'hff);
        core_reset(1'b0, 1'b1);
        check({5'h00, bank_select_field}, 8'h00);
        wr(OFS_BANK_SEL, {5'h00, BANK_4}, 8'hff);
        wr(OFS_PTR_A, 8'h33, 8'hff);
        @(negedge ref_clk);
        rst_b = 1'b0;
        @(negedge ref_clk);
        rst_b = 1'b1;
        check({5'h00, bank_select_field}, 8'h00);
        check(pointer_a, 8'h00);
        check(pointer_b, 8'h00);
        rd(8'h80, 8'hac);
        // a request offered while the clock enable is low is not taken
        clk_en = 1'b0;
        wr(8'h80, 8'h00, 8'hff);
        clk_en = 1'b1;
        rd(8'h80, 8'hac);
        finish_test();
    end
endmodule : data_memory_bank_indirect_access_test

// ---- verification/sfr_model.sv ----
`timescale 1ns/1ps
// peripheral side of the special function space: one plain register, one read-only one
module sfr_model
    import dmem_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic [7:0] acc_addr,
    input  wire logic [7:0] pointer_a,
    input  wire logic [7:0] pointer_b,
    input  wire logic [2:0] bank_select_field,
    input  wire logic       sfr_sel,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_we,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic [7:0] sfr_wmask,
    output logic      [7:0] sfr_rdata,
    output logic            sfr_used,
    output logic            sfr_ro
);
    localparam logic [7:0] RW_ADR = 8'h05;
    localparam logic [7:0] RO_ADR = 8'h08;
    logic [7:0] eff;
    logic [7:0] scratch_q;
    logic [7:0] fixed_q;
    // answer follows the effective address of the access now on offer
    always_comb begin
        eff = acc_addr;
        if (acc_addr == OFS_PORT_A) eff = pointer_a;
        if (acc_addr == OFS_PORT_B) eff = (bank_select_field == BANK_0) ? pointer_b : 8'hff;
    end
    assign sfr_used  = (eff == RW_ADR) || (eff == RO_ADR);
    assign sfr_ro    = (eff == RO_ADR);
    // unused places give a moving value, so a design that forwards it is caught
    assign sfr_rdata = (eff == RW_ADR) ? scratch_q : (eff == RO_ADR) ? fixed_q : ~scratch_q;
    // the read-only cell still takes a strobe: only the design may hold writes back
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            scratch_q <= 8'h00;
            fixed_q   <= 8'h3c;
        end else if (sfr_sel && sfr_we) begin
            if (sfr_addr == RW_ADR) begin
                scratch_q <= (scratch_q & ~sfr_wmask) | (sfr_wdata & sfr_wmask);
            end
            if (sfr_addr == RO_ADR) begin
                fixed_q <= sfr_wdata;
            end
        end
    end
endmodule : sfr_model
